// *** src/nps_map.svh ***
// timing counts, command codes and field positions for the page sequencer controller
`ifndef NPS_MAP_SVH
`define NPS_MAP_SVH
// command codes
`define NPS_CMD_AREA_A 8'h00
`define NPS_CMD_AREA_B 8'h01
`define NPS_CMD_AREA_C 8'h50
`define NPS_CMD_PROG_SETUP 8'h80
`define NPS_CMD_PROG_CONFIRM 8'h10
`define NPS_CMD_ERASE_SETUP 8'h60
`define NPS_CMD_ERASE_CONFIRM 8'hD0
`define NPS_CMD_COPY_SECOND 8'h8A
`define NPS_CMD_READ_STATUS 8'h70
// operation codes on the user port
`define NPS_OP_READ 3'h0
`define NPS_OP_PROGRAM 3'h1
`define NPS_OP_ERASE 3'h2
`define NPS_OP_COPY 3'h3
`define NPS_OP_STATUS 3'h4
// area select codes
`define NPS_AREA_A 2'h0
`define NPS_AREA_B 2'h1
`define NPS_AREA_C 2'h2
// status bit positions
`define NPS_SR_IDLE_BIT 6
`define NPS_SR_ERR_BIT 0
// address field layout
`define NPS_ADDR_BLOCK_LSB 14
// strobe timing in nanoseconds and clock period
`define NPS_CLK_PERIOD_NS 50
`define NPS_STROBE_LOW_NS 50
`define NPS_STROBE_LOW_CYC 4'((`NPS_STROBE_LOW_NS + `NPS_CLK_PERIOD_NS - 1) / `NPS_CLK_PERIOD_NS)
// deselect interval, minimum, rounded up
`define NPS_DESELECT_NS 100
`define NPS_DESELECT_CYC 4'((`NPS_DESELECT_NS + `NPS_CLK_PERIOD_NS - 1) / `NPS_CLK_PERIOD_NS)
// page buffer length in bus words
`define NPS_PAGE_LEN_X8 10'd528
`define NPS_PAGE_LEN_X16 10'd264
`endif

// *** src/nps_pkg.sv ***
// types for the page sequencer controller
package nps_pkg;
  // flash pin outputs, grouped
  typedef struct packed {
    logic ceN;
    logic weN;
    logic reN;
    logic cmdLatch;
    logic addrLatch;
  } nps_pins_t;
  // a user order
  typedef struct packed {
    logic [2:0] op;
    logic [1:0] area;
    logic [25:0] addr;
    logic [25:0] addrDst;
    logic [9:0] count;
  } nps_req_t;
  // sequencer states, gray along write path
  typedef enum logic [3:0] {
    NPS_IDLE = 4'h0,
    NPS_PTR = 4'h1,
    NPS_CMD = 4'h3,
    NPS_ADDR = 4'h2,
    NPS_DATA = 4'h6,
    NPS_CONF = 4'h7,
    NPS_BUSY = 4'h5,
    NPS_RDATA = 4'h4,
    NPS_STAT = 4'hC,
    NPS_CMD2 = 4'hD,
    NPS_ADDR2 = 4'hF,
    NPS_DESEL = 4'hE
  } nps_state_t;
endpackage : nps_pkg

// *** src/nps_sequencer.sv ***
// host-side controller that sequences page operations on a small-page nand flash
`timescale 1ns/1ps
`include "nps_map.svh"
// Notes on behaviour
// - pointer code may precede program setup
// - read pointer followed by four address cycles
// - end row read: chip enable high beyond deselect
// - one to full page per partial program
// - setup, four addresses, data, confirm
// - wait ready, then 8Ah and four addresses
// - copy source and target share top bit
// - failed copy back reports status error
// - erase: 60h, three row addresses, D0h
module nps_sequencer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // user order port
  input wire nps_pkg::nps_req_t req,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [15:0] wrData,
  input wire logic wide16,
  output logic wrTake,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic [7:0] statusByte,
  output logic done,
  output logic opError,
  // flash pins
  output nps_pkg::nps_pins_t pins,
  output logic [15:0] ioOut,
  output logic ioOeN,
  input wire logic [15:0] ioIn,
  input wire logic ready_busy_n
);
  import nps_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic rbMeta_reg, rbSync_reg;
  logic [15:0] ioMeta_reg, ioSync_reg;
  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    rbMeta_reg <= ready_busy_n;
    rbSync_reg <= rbMeta_reg;
    ioMeta_reg <= ioIn;
    ioSync_reg <= ioMeta_reg;
  end

  // ****************************************
  // helpers
  // ****************************************
  // byte for address cycle n; erase skips the column cycle
  function automatic logic [7:0] addrByte(input logic [25:0] a, input logic [2:0] n);
    case (n)
      3'h0: addrByte = a[7:0];
      3'h1: addrByte = a[16:9];
      3'h2: addrByte = a[24:17];
      default: addrByte = {7'h00, a[25]};
    endcase
  endfunction : addrByte
  // pointer code for an area; B falls back to A on x16
  function automatic logic [7:0] ptrCode(input logic [1:0] ar, input logic w16);
    case (ar)
      `NPS_AREA_B: ptrCode = w16 ? `NPS_CMD_AREA_A : `NPS_CMD_AREA_B;
      `NPS_AREA_C: ptrCode = `NPS_CMD_AREA_C;
      default: ptrCode = `NPS_CMD_AREA_A;
    endcase
  endfunction : ptrCode

  // ****************************************
  // sequencer state
  // ****************************************
  nps_state_t state_reg, state_next;
  nps_req_t cur_reg, cur_next;
  nps_pins_t pins_reg, pins_next;
  logic [15:0] io_reg, io_next;
  logic oeN_reg, oeN_next;
  logic [2:0] acnt_reg, acnt_next;    // address cycle index
  logic [9:0] dcnt_reg, dcnt_next;    // data word index
  logic [3:0] tcnt_reg, tcnt_next;    // strobe phase timer
  logic phase_reg, phase_next;        // 0 strobe low, 1 strobe high
  logic [7:0] cmd2_reg, cmd2_next;    // confirm code, or FFh once copy source loaded
  logic [7:0] stat_reg, stat_next;
  logic rdy_reg, rdy_next, done_reg, done_next, err_reg, err_next;
  logic take_reg, take_next, rdv_reg, rdv_next;
  logic [15:0] rd_reg, rd_next;
  logic rbSeenLow_reg, rbSeenLow_next; // busy observed since strobe
  logic [1:0] area_reg, area_next;    // mirror of device pointer

  // next-state logic; each bus cycle is low phase then high phase
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    pins_next = pins_reg;
    io_next = io_reg;
    oeN_next = oeN_reg;
    acnt_next = acnt_reg;
    dcnt_next = dcnt_reg;
    tcnt_next = tcnt_reg;
    phase_next = phase_reg;
    cmd2_next = cmd2_reg;
    stat_next = stat_reg;
    rdy_next = 1'b0;
    done_next = 1'b0;
    err_next = err_reg;
    take_next = 1'b0;
    rdv_next = 1'b0;
    rd_next = rd_reg;
    rbSeenLow_next = rbSeenLow_reg | ~rbSync_reg;
    area_next = area_reg;
    if (tcnt_reg != 4'h0) begin
      tcnt_next = tcnt_reg - 4'h1;
    end else begin
      case (state_reg)
        NPS_IDLE: begin
          pins_next = '{ceN: 1'b1, weN: 1'b1, reN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0};
          oeN_next = 1'b1;
          rdy_next = 1'b1;
          if (reqValid && rdy_reg) begin
            // any op is accepted; codes 5 to 7 run a read setup, then a status read
            cur_next = req;
            rdy_next = 1'b0;
            acnt_next = (req.op == `NPS_OP_ERASE) ? 3'h1 : 3'h0;
            dcnt_next = 10'h000;
            phase_next = 1'b0;
            err_next = 1'b0;
            state_next = (req.op == `NPS_OP_ERASE || req.op == `NPS_OP_STATUS) ? NPS_CMD : NPS_PTR;
          end
        end
        NPS_PTR, NPS_CMD, NPS_CONF, NPS_CMD2: begin
          // command cycle: device latches on write enable rise with latch high
          pins_next.ceN = 1'b0;
          pins_next.cmdLatch = 1'b1;
          pins_next.addrLatch = 1'b0;
          oeN_next = 1'b0;
          if (!phase_reg) begin
            pins_next.weN = 1'b0;
            if (state_reg == NPS_PTR) begin
              // copy back source always uses area A
              io_next = {8'h00, (cur_reg.op == `NPS_OP_COPY) ? `NPS_CMD_AREA_A :
                         ptrCode(cur_reg.area, wide16)};
            end else if (state_reg == NPS_CMD) begin
              io_next = {8'h00, (cur_reg.op == `NPS_OP_PROGRAM) ? `NPS_CMD_PROG_SETUP :
                         (cur_reg.op == `NPS_OP_ERASE) ? `NPS_CMD_ERASE_SETUP :
                         `NPS_CMD_READ_STATUS};
            end else if (state_reg == NPS_CMD2) begin
              io_next = {8'h00, `NPS_CMD_COPY_SECOND};
            end else begin
              io_next = {8'h00, cmd2_reg};
            end
            phase_next = 1'b1;
            tcnt_next = `NPS_STROBE_LOW_CYC - 4'h1;
          end else begin
            pins_next.weN = 1'b1; // rising edge latches the code
            phase_next = 1'b0;
            tcnt_next = `NPS_STROBE_LOW_CYC - 4'h1;
            rbSeenLow_next = 1'b0;
            case (state_reg)
              NPS_PTR: begin
                // pointer lasting one operation is B; A and C persist
                area_next = (cur_reg.op == `NPS_OP_COPY) ? `NPS_AREA_A : cur_reg.area;
                state_next = (cur_reg.op == `NPS_OP_PROGRAM) ? NPS_CMD : NPS_ADDR;
              end
              NPS_CMD: begin
                state_next = (cur_reg.op == `NPS_OP_STATUS) ? NPS_STAT : NPS_ADDR;
                cmd2_next = (cur_reg.op == `NPS_OP_ERASE) ? `NPS_CMD_ERASE_CONFIRM :
                            `NPS_CMD_PROG_CONFIRM;
              end
              NPS_CMD2: state_next = NPS_ADDR2;
              default: begin
                // while busy only status would be accepted, so none is sent
                state_next = NPS_BUSY;
                if (area_reg == `NPS_AREA_B) area_next = `NPS_AREA_A;
              end
            endcase
          end
        end
        NPS_ADDR, NPS_ADDR2: begin
          pins_next.cmdLatch = 1'b0;
          pins_next.addrLatch = 1'b1;
          oeN_next = 1'b0;
          if (!phase_reg) begin
            pins_next.weN = 1'b0;
            // spare area: only low column bits count, rest sent as zero
            if (acnt_reg == 3'h0 && cur_reg.area == `NPS_AREA_C && state_reg == NPS_ADDR)
              io_next = {8'h00, 4'h0, wide16 ? {1'b0, cur_reg.addr[2:0]} : cur_reg.addr[3:0]};
            else if (state_reg == NPS_ADDR2)
              io_next = {8'h00, addrByte({cur_reg.addr[25], cur_reg.addrDst[24:0]}, acnt_reg)};
            else if (cur_reg.op == `NPS_OP_ERASE && acnt_reg == 3'h3)
              io_next = {8'h00, 7'h00, cur_reg.addr[25]};
            else
              io_next = {8'h00, addrByte(cur_reg.addr, acnt_reg)};
            phase_next = 1'b1;
            tcnt_next = `NPS_STROBE_LOW_CYC - 4'h1;
          end else begin
            pins_next.weN = 1'b1;
            phase_next = 1'b0;
            tcnt_next = `NPS_STROBE_LOW_CYC - 4'h1;
            rbSeenLow_next = 1'b0;
            acnt_next = acnt_reg + 3'h1;
            if (acnt_reg == 3'h3) begin
              acnt_next = 3'h0;
              // latch stays high through this rise; the next state drops it
              if (state_reg == NPS_ADDR2) state_next = NPS_BUSY; // 10h skipped
              else if (cur_reg.op == `NPS_OP_PROGRAM) state_next = NPS_DATA;
              else if (cur_reg.op == `NPS_OP_ERASE) state_next = NPS_CONF;
              else state_next = NPS_BUSY;
            end
          end
        end
        NPS_DATA: begin
          pins_next.addrLatch = 1'b0;
          oeN_next = 1'b0;
          if (!phase_reg) begin
            pins_next.weN = 1'b0;
            io_next = wrData;
            take_next = 1'b1;
            phase_next = 1'b1;
            tcnt_next = `NPS_STROBE_LOW_CYC - 4'h1;
          end else begin
            pins_next.weN = 1'b1;
            phase_next = 1'b0;
            tcnt_next = `NPS_STROBE_LOW_CYC - 4'h1;
            dcnt_next = dcnt_reg + 10'h001;
            // 1 to a full page, count holds length minus one
            if (dcnt_reg == cur_reg.count ||
                dcnt_reg == ((wide16 ? `NPS_PAGE_LEN_X16 : `NPS_PAGE_LEN_X8) - 10'h001))
              state_next = NPS_CONF;
          end
        end
        NPS_BUSY: begin
          // wait for ready after busy was seen, sampled two flops late
          oeN_next = 1'b1;
          pins_next.addrLatch = 1'b0; // data reads need the address latch low
          pins_next.cmdLatch = 1'b0;
          if (rbSeenLow_reg && rbSync_reg) begin
            dcnt_next = 10'h000;
            case (cur_reg.op)
              `NPS_OP_READ: state_next = NPS_RDATA;
              `NPS_OP_COPY: state_next = (acnt_reg == 3'h0 && cmd2_reg != 8'hFF) ? NPS_CMD2 : NPS_CMD;
              default: state_next = NPS_CMD;
            endcase
            if (cur_reg.op == `NPS_OP_COPY) cmd2_next = 8'hFF; // marks source loaded
            if (cur_reg.op != `NPS_OP_READ && !(cur_reg.op == `NPS_OP_COPY && cmd2_reg != 8'hFF))
              cur_next.op = `NPS_OP_STATUS; // finish with a status read
          end
        end
        NPS_RDATA, NPS_STAT: begin
          oeN_next = 1'b1;
          pins_next.cmdLatch = 1'b0;
          if (!phase_reg) begin
            pins_next.reN = 1'b0;
            phase_next = 1'b1;
            // two extra cycles: bus data reaches ioSync two flops after the fall
            tcnt_next = `NPS_STROBE_LOW_CYC + 4'h1;
          end else begin
            pins_next.reN = 1'b1;
            phase_next = 1'b0;
            tcnt_next = `NPS_STROBE_LOW_CYC - 4'h1;
            if (state_reg == NPS_STAT) begin
              stat_next = ioSync_reg[7:0];
              err_next = ioSync_reg[`NPS_SR_ERR_BIT];
              done_next = 1'b1;
              state_next = NPS_DESEL;
            end else begin
              rd_next = ioSync_reg;
              rdv_next = 1'b1;
              dcnt_next = dcnt_reg + 10'h001;
              // reading past page end keeps ce low: next page follows
              if (dcnt_reg == cur_reg.count) begin
                done_next = 1'b1;
                state_next = NPS_DESEL;
              end
            end
          end
        end
        NPS_DESEL: begin
          // hold ce high beyond deselect interval to end row read
          pins_next = '{ceN: 1'b1, weN: 1'b1, reN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0};
          tcnt_next = `NPS_DESELECT_CYC;
          state_next = NPS_IDLE;
        end
        default: state_next = NPS_IDLE;
      endcase
    end
    if (!rst_b) area_next = `NPS_AREA_A;
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= NPS_IDLE;
      cur_reg <= '0;
      pins_reg <= '{ceN: 1'b1, weN: 1'b1, reN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0};
      io_reg <= 16'h0000;
      oeN_reg <= 1'b1;
      acnt_reg <= 3'h0;
      dcnt_reg <= 10'h000;
      tcnt_reg <= 4'h0;
      phase_reg <= 1'b0;
      cmd2_reg <= 8'h00;
      stat_reg <= 8'h00;
      rdy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      take_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rd_reg <= 16'h0000;
      rbSeenLow_reg <= 1'b0;
      area_reg <= `NPS_AREA_A;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      pins_reg <= pins_next;
      io_reg <= io_next;
      oeN_reg <= oeN_next;
      acnt_reg <= acnt_next;
      dcnt_reg <= dcnt_next;
      tcnt_reg <= tcnt_next;
      phase_reg <= phase_next;
      cmd2_reg <= cmd2_next;
      stat_reg <= stat_next;
      rdy_reg <= rdy_next;
      done_reg <= done_next;
      err_reg <= err_next;
      take_reg <= take_next;
      rdv_reg <= rdv_next;
      rd_reg <= rd_next;
      rbSeenLow_reg <= rbSeenLow_next;
      area_reg <= area_next;
    end
  end

  // outputs straight from flops
  assign reqReady = rdy_reg;
  assign wrTake = take_reg;
  assign rdData = rd_reg;
  assign rdValid = rdv_reg;
  assign statusByte = stat_reg;
  assign done = done_reg;
  assign opError = err_reg;
  assign pins = pins_reg;
  assign ioOut = io_reg;
  assign ioOeN = oeN_reg;
endmodule : nps_sequencer

// *** verif/nps_sequencer_assertions.sv ***
// checker: port relations of the page sequencer controller
`timescale 1ns/1ps
`include "nps_map.svh"
module nps_sequencer_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // user side
  input wire nps_pkg::nps_req_t req,
  input wire logic reqValid,
  input wire logic reqReady,
  // flash side
  input wire nps_pkg::nps_pins_t pins,
  input wire logic [15:0] ioOut,
  input wire logic ioOeN,
  input wire logic ready_busy_n
);
  import nps_pkg::*;
  // ********************************************
  // one clock domain, reset disables all
  // ********************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic isCmd; // a command strobe is low
  logic taken; // an order is accepted
  assign isCmd = !pins.weN && pins.cmdLatch;
  assign taken = reqValid && reqReady;
  // the device latches at the write rise, so latch and bus must hold there
  a_latch_hold: assert property ($rose(pins.weN) |-> $stable(pins.cmdLatch)
    && $stable(pins.addrLatch) && $stable(ioOut))
    else $error("latch or bus moved at write strobe rise");
  a_latch_excl: assert property (!(pins.cmdLatch && pins.addrLatch))
    else $error("both latch strobes high");
  a_strobe_excl: assert property (!pins.reN |-> pins.weN && ioOeN)
    else $error("read pulse while writing or driving");
  a_strobe_select: assert property (!pins.weN || !pins.reN |-> !pins.ceN)
    else $error("strobe pulse with chip deselected");
  a_deselect_hold: assert property ($rose(pins.ceN) |=> pins.ceN)
    else $error("chip enable high for one cycle only");
  a_erase_setup: assert property (taken && req.op == `NPS_OP_ERASE
    |-> ##[1:20] isCmd && ioOut[7:0] == `NPS_CMD_ERASE_SETUP)
    else $error("erase order without setup code");
  a_prog_setup: assert property (taken && req.op == `NPS_OP_PROGRAM
    |-> ##[1:20] isCmd && ioOut[7:0] == `NPS_CMD_PROG_SETUP)
    else $error("program order without setup code");
  a_copy_second: assert property (taken && req.op == `NPS_OP_COPY
    |-> ##[1:400] isCmd && ioOut[7:0] == `NPS_CMD_COPY_SECOND)
    else $error("copy order without second code");
  a_copy_ready: assert property (isCmd && ioOut[7:0] == `NPS_CMD_COPY_SECOND |-> ready_busy_n)
    else $error("copy second code while device busy");
endmodule : nps_sequencer_assertions
bind nps_sequencer nps_sequencer_assertions i_nps_sequencer_assertions (.core_clk(core_clk),
  .rst_b(rst_b), .req(req), .reqValid(reqValid), .reqReady(reqReady), .pins(pins),
  .ioOut(ioOut), .ioOeN(ioOeN), .ready_busy_n(ready_busy_n));

// *** verif/nps_flash_model.sv ***
// behavioural x8 small-page flash on the far side of the controller
`timescale 1ns/1ps
module nps_flash_model #(
  parameter int BUSY_NS = 600 // array time, kept short
) (
  // strobes and bus from the controller
  input wire nps_pkg::nps_pins_t pins,
  input wire logic [15:0] ioOut,
  // bus back and ready line
  output logic [15:0] ioIn,
  output logic ready_busy_n,
  // makes copy back report a failure
  input wire logic failCopy
);
  import nps_pkg::*;
  logic [7:0] mem [int]; // absent entry reads erased
  logic [7:0] pb [int]; // page buffer by column
  logic [7:0] ab [0:3]; // address cycles
  logic [7:0] cmd; // last accepted code
  logic [1:0] ptr; // area pointer
  logic err; // status error bit
  logic stat; // status read mode
  int na; // address cycles seen
  int col; // column pointer
  int pg; // page number
  event goBusy; // starts an array busy time
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd
  // whole page into the buffer
  task automatic load();
    for (int c = 0; c < 528; c++) pb[c] = rd(pg * 528 + c);
  endtask : load
  // ones may only turn to zeros
  task automatic burn(input int p);
    foreach (pb[c]) mem[p * 528 + c] = rd(p * 528 + c) & pb[c];
    stat = 1'b1;
    if (ptr == 2'h1) ptr = 2'h0;
    ->goBusy;
  endtask : burn
  initial begin
    ioIn = 16'h0000;
    ready_busy_n = 1'b1;
    ptr = 2'h0;
    cmd = 8'hFF;
    err = 1'b0;
    stat = 1'b0;
    na = 0;
  end
  // ready line low for the array time
  always begin
    @goBusy;
    ready_busy_n = 1'b0;
    #(BUSY_NS);
    ready_busy_n = 1'b1;
  end
  // cycles land on the write rise
  always @(posedge pins.weN) begin
    if (!pins.ceN && pins.cmdLatch) begin
      if (ready_busy_n || ioOut[7:0] == 8'h70 || ioOut[7:0] == 8'hFF) begin
        na = 0;
        stat = (ioOut[7:0] == 8'h70);
        case (ioOut[7:0])
          8'h00, 8'hFF: ptr = 2'h0;
          8'h01: ptr = 2'h1;
          8'h50: ptr = 2'h2;
          8'h80: pb.delete();
          8'h10: if (cmd == 8'h80) burn(pg);
          8'hD0: if (cmd == 8'h60) begin
            pg = {ab[2][0], ab[1], ab[0]} & 32'h1FFE0;
            for (int a = pg * 528; a < (pg + 32) * 528; a++) mem.delete(a);
            err = 1'b0;
            stat = 1'b1;
            ->goBusy;
          end
          default: ;
        endcase
        cmd = ioOut[7:0];
      end
    end else if (!pins.ceN && pins.addrLatch && na < 4) begin
      ab[na] = ioOut[7:0];
      na++;
      if (na == 4) begin
        pg = {ab[3][0], ab[2], ab[1]};
        col = (ptr == 2'h2) ? 512 + ab[0][3:0] : ptr * 256 + ab[0];
        if (cmd == 8'h8A) begin
          err = failCopy;
          burn(pg);
        end else if (cmd != 8'h80) begin
          load();
          if (ptr == 2'h1) ptr = 2'h0;
          ->goBusy;
        end else begin
          err = 1'b0;
        end
      end
    end else if (!pins.ceN && !pins.cmdLatch && !pins.addrLatch && cmd == 8'h80) begin
      pb[col] = ioOut[7:0];
      col++;
    end
  end
  // data leaves on the read fall
  always @(negedge pins.reN) begin
    if (stat) begin
      ioIn = {8'h00, 8'hC0 | {7'h00, err}};
    end else begin
      ioIn = {8'h00, pb[col]};
      col++;
      if (col == 528) begin
        pg++;
        col = 0;
        load();
      end
    end
  end
  // output hold runs out: show no stale value
  always @(posedge pins.reN) begin
    #90;
    if (pins.reN) ioIn = ~ioIn;
  end
endmodule : nps_flash_model

// *** verif/tb_nps_sequencer.sv ***
// self-checking bench for the page sequencer controller
`timescale 1ns/1ps
`include "nps_map.svh"
module tb_nps_sequencer;
  import nps_pkg::*;
  logic core_clk = 1'b0; // 20 MHz
  logic rst_b = 1'b0; // held for three edges
  nps_req_t req = '0; // user order
  logic reqValid = 1'b0;
  logic [15:0] wrData = 16'h0000;
  logic wide16 = 1'b0; // x8 part
  logic failCopy = 1'b0; // model fault switch
  logic reqReady, wrTake, rdValid, done, opError, ioOeN, ready_busy_n;
  logic [15:0] rdData, ioOut, ioIn;
  logic [7:0] statusByte;
  nps_pins_t pins;
  logic [7:0] wb [0:3]; // program bytes
  logic [7:0] rq [$]; // read bytes seen
  int err_count = 0;
  int comparisons = 0;
  int wi = 0; // word index
  always #25 core_clk = ~core_clk;
  nps_sequencer i_nps_sequencer (.core_clk(core_clk), .rst_b(rst_b), .req(req),
    .reqValid(reqValid), .reqReady(reqReady), .wrData(wrData), .wide16(wide16),
    .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .statusByte(statusByte),
    .done(done), .opError(opError), .pins(pins), .ioOut(ioOut), .ioOeN(ioOeN),
    .ioIn(ioIn), .ready_busy_n(ready_busy_n));
  nps_flash_model i_nps_flash_model (.pins(pins), .ioOut(ioOut), .ioIn(ioIn),
    .ready_busy_n(ready_busy_n), .failCopy(failCopy));
  // next word after each take, read words into the queue
  always @(posedge core_clk) begin
    if (wrTake === 1'b1) begin
      wi <= wi + 1;
      wrData <= {8'h00, wb[(wi + 1) & 3]};
    end
    if (rdValid === 1'b1) rq.push_back(rdData[7:0]);
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // one order, held until taken, then bounded wait for done
  task automatic order(input logic [2:0] op, input logic [1:0] ar, input logic [25:0] a,
      input logic [25:0] d, input logic [9:0] n);
    int t;
    rq.delete();
    wi <= 0;
    wrData <= {8'h00, wb[0]};
    req <= '{op: op, area: ar, addr: a, addrDst: d, count: n};
    reqValid <= 1'b1;
    do @(posedge core_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (done !== 1'b1 && t < 4000);
    chk("done", 8'h01, {7'h00, done});
    @(posedge core_clk); // one spare edge; the last read word was queued at the edge that ended the wait
  endtask : order
  task automatic stchk(input logic [7:0] e);
    chk("statusByte", e, statusByte);
    chk("opError", {7'h00, e[0]}, {7'h00, opError});
  endtask : stchk
  task automatic prog(input logic [1:0] ar, input logic [25:0] a, input logic [31:0] v,
      input logic [9:0] n);
    for (int i = 0; i < 4; i++) wb[i] = v[31 - 8 * i -: 8];
    order(`NPS_OP_PROGRAM, ar, a, 26'h0, n);
    stchk(8'hC0);
  endtask : prog
  // four bytes read from a start column
  task automatic rdchk(input logic [1:0] ar, input logic [25:0] a, input logic [31:0] e);
    order(`NPS_OP_READ, ar, a, 26'h0, 10'd3);
    for (int i = 0; i < 4; i++) chk("rdData", e[31 - 8 * i -: 8], rq[i]);
  endtask : rdchk
  function automatic logic [25:0] pa(input logic [16:0] p, input logic [7:0] c);
    return {p, 1'b0, c};
  endfunction : pa
  // ********************************************
  // watchdog
  // ********************************************
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  // ********************************************
  // main sequence
  // ********************************************
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    prog(`NPS_AREA_A, pa(64, 0), 32'h12345678, 10'd3);
    rdchk(`NPS_AREA_A, pa(64, 0), 32'h12345678);
    order(`NPS_OP_ERASE, `NPS_AREA_A, pa(64, 0), 26'h0, 10'd0);
    stchk(8'hC0);
    rdchk(`NPS_AREA_A, pa(64, 0), 32'hFFFFFFFF);
    prog(`NPS_AREA_B, pa(65, 4), 32'hA55A0000, 10'd1);
    rdchk(`NPS_AREA_B, pa(65, 4), 32'hA55AFFFF);
    rdchk(`NPS_AREA_A, pa(65, 4), 32'hFFFFFFFF);
    prog(`NPS_AREA_C, pa(66, 2), 32'h3CC30000, 10'd1);
    rdchk(`NPS_AREA_C, pa(66, 8'h12), 32'h3CC3FFFF);
    prog(`NPS_AREA_A, pa(66, 0), 32'hF0000000, 10'd0);
    prog(`NPS_AREA_A, pa(66, 0), 32'h3C000000, 10'd0);
    rdchk(`NPS_AREA_A, pa(66, 0), 32'h30FFFFFF);
    prog(`NPS_AREA_C, pa(67, 14), 32'h11220000, 10'd1);
    prog(`NPS_AREA_A, pa(68, 0), 32'h33440000, 10'd1);
    rdchk(`NPS_AREA_C, pa(67, 14), 32'h11223344);
    order(`NPS_OP_COPY, `NPS_AREA_A, pa(66, 0), pa(69, 0), 10'd0);
    stchk(8'hC0);
    rdchk(`NPS_AREA_A, pa(69, 0), 32'h30FFFFFF);
    rdchk(`NPS_AREA_C, pa(69, 2), 32'h3CC3FFFF);
    failCopy <= 1'b1;
    order(`NPS_OP_COPY, `NPS_AREA_A, pa(66, 0), pa(70, 0), 10'd0);
    stchk(8'hC1);
    failCopy <= 1'b0;
    order(`NPS_OP_STATUS, `NPS_AREA_A, 26'h0, 26'h0, 10'd0);
    stchk(8'hC1);
    summarize();
  end
endmodule : tb_nps_sequencer
